// ---- rtl/panel_cfg.svh ----
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH
// clock and timing, times in their own unit, counts derived at 100 MHz
`define CLK_HZ            100000000
`define TICK_MS           1
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define DEBOUNCE_MS       20
`define DWELL_MS          1500
`define FLASH_HALF_MS     100
`define FEEDBACK_MS       300
`define TEST_TIMEOUT_MS   120000
`define LEARN_TIMEOUT_MS  180000
`define LEARN_SOLID_MS    1000
`define RESTORE_ON_MS     1000
`define RESTORE_OFF_MS    500
`define DEFAULT_FLASHES   3
`define MS_W              18
`define NUM_LAMPS         5
// lamp bit positions
`define LAMP_READY        0
`define LAMP_GOOD         1
`define LAMP_TRIG         2
`define LAMP_COM          3
`define LAMP_STATUS       4
// read rate percentages scaled 0..100
`define RATE_W            7
`define RATE_STEP         20
`endif

// ---- rtl/panel_pkg.sv ----
package panel_pkg;
   typedef enum {
      ST_BOOT, ST_RUN, ST_FEEDBACK, ST_CYCLE, ST_TEST, ST_LEARN, ST_LEARN_OK,
      ST_SETUP, ST_DISCOVER, ST_RESTORE_HOLD, ST_RESTORE_OFF, ST_RECOVERY, ST_DEFAULTS
   } panel_state_e;
   typedef enum {SEL_TEST, SEL_LEARN, SEL_SETUP, SEL_DISCOVER} panel_sel_e;
endpackage

// ---- rtl/button_debounce.sv ----
`timescale 1ns/1ps
`include "panel_cfg.svh"
module button_debounce #(
   parameter int STABLE_MS = `DEBOUNCE_MS
) (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic tick_i,
   input  wire logic raw_i,
   output logic      level_o
);
   initial begin
      if (STABLE_MS < 1) $error("STABLE_MS must be at least 1");
   end
   typedef struct packed {
      logic              level;
      logic [`MS_W-1:0]  cnt;
   } deb_s;
   deb_s s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (raw_i == s_q.level) begin
         s_d.cnt = '0;
      end else if (tick_i) begin
         if (s_q.cnt == `MS_W'(STABLE_MS - 1)) begin
            s_d.level = raw_i;
            s_d.cnt   = '0;
         end else begin
            s_d.cnt = s_q.cnt + `MS_W'(1);
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign level_o = s_q.level;
endmodule

// ---- rtl/operator_panel.sv ----
// Operation
// - ready lamp steady green while unit ready to operate
// - good-read lamp flashes on each successful decode
// - trigger lamp flashes while presence sensor input active
// - communication lamp flashes while main serial port transmits
// - slave in tracking mode keeps trigger and communication lamps dark
// - function press first gives status lamp feedback
// - held button steps function lamps; release enters lit function
// - test mode shows read rate as five-lamp bar graph
// - test mode no read: only status lamp, blinking
// - test mode ends on a press or after two minutes
// - learn lamp blinks while searching, solid briefly after save
// - learn abandoned, parameters discarded after about three minutes
// - setup offered only in chain whose master is a scanner
// - setup makes last slave port configuration-only, ring traffic stopped
// - discovery on master finds slaves; ends on further press
// - restore held lights all; then ready relit, box parameters used
// - function held at power-up starts software recovery
// - both held at power-up restores defaults, flashes all three times
`timescale 1ns/1ps
`include "panel_cfg.svh"
module operator_panel
   import panel_pkg::*;
#(
   parameter int TICK_CYCLES      = `TICK_CYCLES,
   parameter int TEST_TIMEOUT_MS  = `TEST_TIMEOUT_MS,
   parameter int LEARN_TIMEOUT_MS = `LEARN_TIMEOUT_MS,
   parameter int DWELL_MS         = `DWELL_MS,
   parameter int DEBOUNCE_MS      = `DEBOUNCE_MS
) (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_n_i,
   // panel buttons, high while pressed
   input  wire logic                func_button_i,
   input  wire logic                restore_button_i,
   // device status
   input  wire logic                unit_ready_i,
   input  wire logic                decode_ok_i,
   input  wire logic                presence_i,
   input  wire logic                serial_tx_i,
   input  wire logic                role_slave_i,
   input  wire logic                role_master_i,
   input  wire logic                tracking_mode_i,
   input  wire logic                chain_scanner_master_i,
   input  wire logic                last_slave_i,
   input  wire logic [`RATE_W-1:0]  read_rate_i,
   input  wire logic                learn_saved_i,
   input  wire logic                defaults_done_i,
   // lamps
   output logic [`NUM_LAMPS-1:0]    lamp_o,
   // mode outputs
   output logic                     test_mode_o,
   output logic                     learn_mode_o,
   output logic                     learn_discard_o,
   output logic                     setup_port_only_o,
   output logic                     discovery_mode_o,
   output logic                     use_box_params_o,
   output logic                     recovery_mode_o,
   output logic                     factory_restore_o
);
   initial begin
      if (TICK_CYCLES < 1 || TEST_TIMEOUT_MS < 1 || LEARN_TIMEOUT_MS < 1 || DWELL_MS < 1)
         $error("timing parameters must be positive");
      if (TEST_TIMEOUT_MS >= (1 << `MS_W) || LEARN_TIMEOUT_MS >= (1 << `MS_W))
         $error("timeouts exceed counter width");
   end

   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      panel_state_e        st;
      panel_sel_e          sel;
      logic [TW-1:0]       tdiv;
      logic                tick;
      logic [`MS_W-1:0]    ms;
      logic [`MS_W-1:0]    fl;
      logic                blink;
      logic                fb_seen;
      logic                func_prev;
      logic [1:0]          flashes;
      logic                good_hold;
      logic [`MS_W-1:0]    good_ms;
      logic [`NUM_LAMPS-1:0] lamp;
      logic                test, learn, discard, setup, disc, box, recov, fact;
   } panel_s;

   panel_s s_q, s_d;
   logic   func_lvl, rest_lvl;

   button_debounce #(.STABLE_MS(DEBOUNCE_MS)) u_func_deb (
      .clk_i    (clk_i),
      .reset_n_i(reset_n_i),
      .tick_i   (s_q.tick),
      .raw_i    (func_button_i),
      .level_o  (func_lvl)
   );
   button_debounce #(.STABLE_MS(DEBOUNCE_MS)) u_rest_deb (
      .clk_i    (clk_i),
      .reset_n_i(reset_n_i),
      .tick_i   (s_q.tick),
      .raw_i    (restore_button_i),
      .level_o  (rest_lvl)
   );

   function automatic logic ms_done(input logic [`MS_W-1:0] c, input int lim);
      return c >= `MS_W'(lim);
   endfunction

   function automatic logic [`NUM_LAMPS-1:0] bar(input logic [`RATE_W-1:0] r);
      logic [`NUM_LAMPS-1:0] b;
      b = '0;
      for (int i = 0; i < `NUM_LAMPS; i++) begin
         if (r > `RATE_W'(i * `RATE_STEP)) b[i] = 1'b1;
      end
      return b;
   endfunction

   function automatic logic setup_ok(input logic scanner_master);
      return scanner_master;
   endfunction

   logic press;
   logic [`NUM_LAMPS-1:0] all_on;

   always_comb begin
      s_d = s_q;
      all_on = '1;
      press = func_lvl && !s_q.func_prev;
      s_d.func_prev = func_lvl;
      // one millisecond enable from the divider
      s_d.tick = 1'b0;
      if (s_q.tdiv == TW'(TICK_CYCLES - 1)) begin
         s_d.tdiv = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.tdiv = s_q.tdiv + TW'(1);
      end
      if (s_q.tick) begin
         s_d.ms = s_q.ms + `MS_W'(1);
         if (ms_done(s_q.fl, `FLASH_HALF_MS - 1)) begin
            s_d.fl = '0;
            s_d.blink = !s_q.blink;
         end else begin
            s_d.fl = s_q.fl + `MS_W'(1);
         end
         if (s_q.good_hold) s_d.good_ms = s_q.good_ms + `MS_W'(1);
      end
      // good read stretched so a one-cycle decode pulse is visible
      if (decode_ok_i) begin
         s_d.good_hold = 1'b1;
         s_d.good_ms = '0;
      end else if (s_q.good_hold && ms_done(s_q.good_ms, 2 * `FLASH_HALF_MS)) begin
         s_d.good_hold = 1'b0;
      end
      s_d.discard = 1'b0;
      s_d.lamp = '0;

      case (s_q.st)
         ST_BOOT: begin
            // buttons get twice the debounce time to settle before straps are judged
            if (ms_done(s_q.ms, 2 * DEBOUNCE_MS)) begin
               s_d.ms = '0;
               if (func_lvl && rest_lvl) begin
                  s_d.st = ST_DEFAULTS;
                  s_d.fact = 1'b1;
                  s_d.flashes = '0;
               end else if (func_lvl) begin
                  s_d.st = ST_RECOVERY;
                  s_d.recov = 1'b1;
               end else begin
                  s_d.st = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            s_d.lamp[`LAMP_READY] = unit_ready_i;
            s_d.lamp[`LAMP_GOOD]  = s_q.good_hold && s_q.blink;
            if (!(role_slave_i && tracking_mode_i)) begin
               s_d.lamp[`LAMP_TRIG] = presence_i && s_q.blink;
               s_d.lamp[`LAMP_COM]  = serial_tx_i && s_q.blink;
            end
            if (press) begin
               s_d.st = ST_FEEDBACK;
               s_d.ms = '0;
            end else if (rest_lvl) begin
               s_d.st = ST_RESTORE_HOLD;
               s_d.ms = '0;
            end
         end
         ST_FEEDBACK: begin
            s_d.lamp[`LAMP_STATUS] = 1'b1;
            if (!func_lvl) begin
               s_d.st = ST_RUN;
            end else if (ms_done(s_q.ms, `FEEDBACK_MS)) begin
               s_d.st = ST_CYCLE;
               s_d.sel = SEL_TEST;
               s_d.ms = '0;
            end
         end
         ST_CYCLE: begin
            case (s_q.sel)
               SEL_TEST:     s_d.lamp[`LAMP_COM]   = 1'b1;
               SEL_LEARN:    s_d.lamp[`LAMP_TRIG]  = 1'b1;
               SEL_SETUP:    s_d.lamp[`LAMP_GOOD]  = 1'b1;
               default:      s_d.lamp[`LAMP_READY] = 1'b1;
            endcase
            if (!func_lvl) begin
               s_d.ms = '0;
               case (s_q.sel)
                  SEL_TEST: begin
                     s_d.st = ST_TEST;
                     s_d.test = 1'b1;
                  end
                  SEL_LEARN: begin
                     s_d.st = ST_LEARN;
                     s_d.learn = 1'b1;
                  end
                  SEL_SETUP: begin
                     if (setup_ok(chain_scanner_master_i)) begin
                        s_d.st = ST_SETUP;
                        s_d.setup = last_slave_i;
                     end else begin
                        s_d.st = ST_RUN;
                     end
                  end
                  default: begin
                     if (role_master_i) begin
                        s_d.st = ST_DISCOVER;
                        s_d.disc = 1'b1;
                     end else begin
                        s_d.st = ST_RUN;
                     end
                  end
               endcase
            end else if (ms_done(s_q.ms, DWELL_MS)) begin
               s_d.ms = '0;
               case (s_q.sel)
                  SEL_TEST:  s_d.sel = SEL_LEARN;
                  SEL_LEARN: s_d.sel = SEL_SETUP;
                  SEL_SETUP: s_d.sel = SEL_DISCOVER;
                  default:   s_d.sel = SEL_TEST;
               endcase
            end
         end
         ST_TEST: begin
            if (read_rate_i == '0) begin
               s_d.lamp[`LAMP_STATUS] = s_q.blink;
            end else begin
               s_d.lamp = bar(read_rate_i);
            end
            if (press || ms_done(s_q.ms, TEST_TIMEOUT_MS)) begin
               s_d.st = ST_RUN;
               s_d.test = 1'b0;
            end
         end
         ST_LEARN: begin
            s_d.lamp[`LAMP_TRIG] = s_q.blink;
            if (learn_saved_i) begin
               s_d.st = ST_LEARN_OK;
               s_d.ms = '0;
            end else if (ms_done(s_q.ms, LEARN_TIMEOUT_MS)) begin
               s_d.st = ST_RUN;
               s_d.learn = 1'b0;
               s_d.discard = 1'b1;
            end
         end
         ST_LEARN_OK: begin
            s_d.lamp[`LAMP_TRIG] = 1'b1;
            if (ms_done(s_q.ms, `LEARN_SOLID_MS)) begin
               s_d.st = ST_RUN;
               s_d.learn = 1'b0;
            end
         end
         ST_SETUP: begin
            // setup persists; port keeps serving configuration traffic
            s_d.lamp[`LAMP_READY] = unit_ready_i;
            s_d.lamp[`LAMP_GOOD]  = 1'b1;
            if (press) begin
               s_d.st = ST_RUN;
               s_d.setup = 1'b0;
            end
         end
         ST_DISCOVER: begin
            s_d.lamp[`LAMP_READY] = s_q.blink;
            if (press) begin
               s_d.st = ST_RUN;
               s_d.disc = 1'b0;
            end
         end
         ST_RESTORE_HOLD: begin
            s_d.lamp = all_on;
            if (!rest_lvl && ms_done(s_q.ms, `RESTORE_ON_MS)) begin
               s_d.st = ST_RESTORE_OFF;
               s_d.ms = '0;
            end else if (!rest_lvl) begin
               s_d.st = ST_RUN;
            end
         end
         ST_RESTORE_OFF: begin
            if (ms_done(s_q.ms, `RESTORE_OFF_MS)) begin
               s_d.st = ST_RUN;
               s_d.box = 1'b1;
            end
         end
         ST_RECOVERY: begin
            s_d.lamp[`LAMP_STATUS] = 1'b1;
         end
         ST_DEFAULTS: begin
            // ms is a started flag here, so no flash is shown before the restore succeeds
            s_d.ms = s_q.ms;
            if (defaults_done_i && s_q.flashes == '0 && s_q.ms == '0) begin
               s_d.ms    = `MS_W'(1);
               s_d.fl    = '0;
               s_d.blink = 1'b1;
            end
            if (s_q.ms != '0) begin
               s_d.lamp = s_q.blink ? all_on : '0;
               // a flash is counted when its lit half ends, so the exit leaves the lamps dark
               if (s_q.tick && s_q.fl == '0 && !s_q.blink) begin
                  if (s_q.flashes == 2'(`DEFAULT_FLASHES - 1)) begin
                     s_d.st = ST_RUN;
                     s_d.fact = 1'b0;
                  end else begin
                     s_d.flashes = s_q.flashes + 2'(1);
                  end
               end
            end
         end
         default: s_d.st = ST_BOOT;
      endcase
      s_d.test = (s_d.st == ST_TEST);
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_q    <= '0;
         s_q.st <= ST_BOOT;
      end else begin
         s_q <= s_d;
      end
   end

   assign lamp_o            = s_q.lamp;
   assign test_mode_o       = s_q.test;
   assign learn_mode_o      = s_q.learn;
   assign learn_discard_o   = s_q.discard;
   assign setup_port_only_o = s_q.setup;
   assign discovery_mode_o  = s_q.disc;
   assign use_box_params_o  = s_q.box;
   assign recovery_mode_o   = s_q.recov;
   assign factory_restore_o = s_q.fact;
endmodule

// ---- testbench/operator_panel_chk.sv ----
`timescale 1ns/1ps
`include "panel_cfg.svh"
module operator_panel_chk #(
   parameter int TICK_CYCLES      = 10,
   parameter int TEST_TIMEOUT_MS  = 50,
   parameter int LEARN_TIMEOUT_MS = 50
) (
   // clock, reset, buttons
   input wire logic                clk_i,
   input wire logic                reset_n_i,
   input wire logic                func_button_i,
   input wire logic                restore_button_i,
   // status and config
   input wire logic                unit_ready_i,
   input wire logic                role_slave_i,
   input wire logic                role_master_i,
   input wire logic                tracking_mode_i,
   input wire logic                chain_scanner_master_i,
   input wire logic                last_slave_i,
   input wire logic [`RATE_W-1:0]  read_rate_i,
   // outputs watched
   input wire logic [`NUM_LAMPS-1:0] lamp_o,
   input wire logic                test_mode_o,
   input wire logic                learn_mode_o,
   input wire logic                learn_discard_o,
   input wire logic                setup_port_only_o,
   input wire logic                discovery_mode_o,
   input wire logic                use_box_params_o,
   input wire logic                recovery_mode_o,
   input wire logic                factory_restore_o
);
   // long enough to outlast the restore off phase, learn hold and default flashes
   localparam int QUIET     = 1200 * TICK_CYCLES;
   localparam int TEST_MAX  = (TEST_TIMEOUT_MS + 2) * TICK_CYCLES;
   localparam int LEARN_MIN = (LEARN_TIMEOUT_MS - 1) * TICK_CYCLES;
   localparam int LEARN_MAX = (LEARN_TIMEOUT_MS + 2) * TICK_CYCLES;
   int   quiet_q;
   int   test_q;
   int   learn_q;
   logic learn_prev_q;
   wire logic any_mode = test_mode_o | learn_mode_o | setup_port_only_o | discovery_mode_o |
                         recovery_mode_o | factory_restore_o;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         quiet_q <= 0;
         test_q <= 0;
         learn_q <= 0;
         learn_prev_q <= 1'b0;
      end else begin
         quiet_q <= (func_button_i | restore_button_i | any_mode) ? 0 : (quiet_q < QUIET ? quiet_q + 1 : quiet_q);
         test_q <= test_mode_o ? test_q + 1 : 0;
         learn_q <= (learn_mode_o && !learn_prev_q) ? 1 : (learn_mode_o ? learn_q + 1 : learn_q);
         learn_prev_q <= learn_mode_o;
      end
   end
   function automatic int bars(input logic [`RATE_W-1:0] r);
      int n = 0;
      for (int i = 0; i < 5; i++) if (r > 20 * i) n++;
      return n;
   endfunction
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_reset_quiet;
      disable iff (1'b0) !reset_n_i |=> lamp_o == 5'h00 && !any_mode && !use_box_params_o && !learn_discard_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear in reset");
   property p_ready_lamp;
      quiet_q == QUIET && $stable(unit_ready_i) |-> lamp_o[0] == unit_ready_i;
   endproperty
   a_ready_lamp: assert property (p_ready_lamp) else $error("ready lamp wrong");
   property p_slave_dark;
      quiet_q == QUIET && role_slave_i && tracking_mode_i && $stable(role_slave_i) && $stable(tracking_mode_i)
         |-> lamp_o[3:2] == 2'b00;
   endproperty
   a_slave_dark: assert property (p_slave_dark) else $error("slave lamps lit");
   property p_one_mode;
      $onehot0({test_mode_o, learn_mode_o, setup_port_only_o, discovery_mode_o});
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("two functions at once");
   property p_test_bar;
      test_mode_o && $past(test_mode_o) && $stable(read_rate_i) |->
         (read_rate_i == 7'h00 ? lamp_o[3:0] == 4'h0 : $countones(lamp_o) == bars(read_rate_i));
   endproperty
   a_test_bar: assert property (p_test_bar) else $error("bar graph wrong");
   property p_test_timeout;
      test_q <= TEST_MAX;
   endproperty
   a_test_timeout: assert property (p_test_timeout) else $error("test mode overran");
   property p_discard_pulse;
      learn_discard_o |=> !learn_discard_o;
   endproperty
   a_discard_pulse: assert property (p_discard_pulse) else $error("discard not a pulse");
   property p_discard_time;
      learn_discard_o |-> learn_q >= LEARN_MIN && learn_q <= LEARN_MAX;
   endproperty
   a_discard_time: assert property (p_discard_time) else $error("learn discard mistimed");
   property p_setup_chain;
      setup_port_only_o |-> chain_scanner_master_i && last_slave_i;
   endproperty
   a_setup_chain: assert property (p_setup_chain) else $error("setup outside chain");
   property p_discovery_master;
      $rose(discovery_mode_o) |-> $past(role_master_i);
   endproperty
   a_discovery_master: assert property (p_discovery_master) else $error("discovery off master");
   c_test: cover property ($rose(test_mode_o));
   c_discard: cover property (learn_discard_o);
   c_box: cover property ($rose(use_box_params_o));
   c_recovery: cover property ($rose(recovery_mode_o));
endmodule

bind operator_panel operator_panel_chk #(
   .TICK_CYCLES(TICK_CYCLES), .TEST_TIMEOUT_MS(TEST_TIMEOUT_MS), .LEARN_TIMEOUT_MS(LEARN_TIMEOUT_MS)
) u_operator_panel_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .func_button_i(func_button_i), .restore_button_i(restore_button_i),
   .unit_ready_i(unit_ready_i), .role_slave_i(role_slave_i), .role_master_i(role_master_i),
   .tracking_mode_i(tracking_mode_i), .chain_scanner_master_i(chain_scanner_master_i),
   .last_slave_i(last_slave_i), .read_rate_i(read_rate_i), .lamp_o(lamp_o), .test_mode_o(test_mode_o),
   .learn_mode_o(learn_mode_o), .learn_discard_o(learn_discard_o), .setup_port_only_o(setup_port_only_o),
   .discovery_mode_o(discovery_mode_o), .use_box_params_o(use_box_params_o),
   .recovery_mode_o(recovery_mode_o), .factory_restore_o(factory_restore_o)
);

// ---- testbench/operator_model.sv ----
`timescale 1ns/1ps
module operator_model (
   // bench side
   input  wire logic       clk_i,
   input  wire logic [1:0] want_i,
   // buttons, bit 0 function, bit 1 restore
   output logic [1:0]      button_o
);
   logic [1:0] held_q = 2'b00;
   int         chatter[2] = '{0, 0};
   initial button_o = 2'b00;
   // contacts chatter a few cycles on every change, well inside the debounce span
   always @(negedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (want_i[i] !== held_q[i]) begin
            held_q[i] = want_i[i];
            chatter[i] = 7;
         end
         if (chatter[i] > 0) chatter[i]--;
         button_o[i] <= (chatter[i] % 2 == 1) ? ~held_q[i] : held_q[i];
      end
   end
endmodule

// ---- testbench/operator_panel_tb.sv ----
`timescale 1ns/1ps
`include "panel_cfg.svh"
module operator_panel_tb;
   import panel_pkg::*;
   localparam int TICK = 10;
   logic clk_i = 1'b0, reset_n_i = 1'b0;
   logic [1:0] want = 2'b00, button;
   logic unit_ready_i = 1'b1, decode_ok_i = 1'b0, presence_i = 1'b0, serial_tx_i = 1'b0;
   logic role_slave_i = 1'b0, role_master_i = 1'b0, tracking_mode_i = 1'b0;
   logic chain_scanner_master_i = 1'b0, last_slave_i = 1'b0, learn_saved_i = 1'b0, defaults_done_i = 1'b0;
   logic [`RATE_W-1:0] read_rate_i = 7'h32;
   logic [`NUM_LAMPS-1:0] lamp_o;
   logic test_mode_o, learn_mode_o, learn_discard_o, setup_port_only_o;
   logic discovery_mode_o, use_box_params_o, recovery_mode_o, factory_restore_o;
   logic all_q = 1'b0;
   int n_mismatch = 0, n_tests = 0, n_all = 0, n_discard = 0, n;
   always #5 clk_i = ~clk_i;
   operator_model u_operator_model (.clk_i(clk_i), .want_i(want), .button_o(button));
   operator_panel #(.TICK_CYCLES(TICK), .TEST_TIMEOUT_MS(50), .LEARN_TIMEOUT_MS(300), .DWELL_MS(20),
      .DEBOUNCE_MS(2)) u_operator_panel (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .func_button_i(button[0]), .restore_button_i(button[1]),
      .unit_ready_i(unit_ready_i), .decode_ok_i(decode_ok_i), .presence_i(presence_i),
      .serial_tx_i(serial_tx_i), .role_slave_i(role_slave_i), .role_master_i(role_master_i),
      .tracking_mode_i(tracking_mode_i), .chain_scanner_master_i(chain_scanner_master_i),
      .last_slave_i(last_slave_i), .read_rate_i(read_rate_i), .learn_saved_i(learn_saved_i),
      .defaults_done_i(defaults_done_i), .lamp_o(lamp_o), .test_mode_o(test_mode_o),
      .learn_mode_o(learn_mode_o), .learn_discard_o(learn_discard_o), .setup_port_only_o(setup_port_only_o),
      .discovery_mode_o(discovery_mode_o), .use_box_params_o(use_box_params_o),
      .recovery_mode_o(recovery_mode_o), .factory_restore_o(factory_restore_o));
   always @(posedge clk_i) begin
      all_q <= (lamp_o === 5'h1F);
      if (lamp_o === 5'h1F && !all_q) n_all++;
      if (learn_discard_o === 1'b1) n_discard++;
   end
   task automatic wait_ms(input int ms);
      repeat (ms * TICK) @(negedge clk_i);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic do_reset(input logic [1:0] hold);
      want = hold;
      reset_n_i = 1'b0;
      repeat (6) @(negedge clk_i);
      reset_n_i = 1'b1;
   endtask
   task automatic hold_func(input int ms);
      want = 2'b01;
      wait_ms(ms);
      want = 2'b00;
   endtask
   // lamps are sampled every 10 ms over 200 ms, one full flash period
   task automatic count_lit(input logic [4:0] mask, output int cnt);
      cnt = 0;
      repeat (20) begin
         wait_ms(10);
         cnt += ((lamp_o & mask) !== 5'h00);
      end
   endtask
   task final_report;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1_100_000;
      n_mismatch++;
      final_report();
   end
   initial begin
      do_reset(2'b00);
      check(lamp_o, 5'h00);
      role_slave_i = 1'b1;
      tracking_mode_i = 1'b1;
      presence_i = 1'b1;
      serial_tx_i = 1'b1;
      wait_ms(1300);
      count_lit(5'h0C, n);
      check(n, 0);
      check(lamp_o[0], 1'b1);
      role_slave_i = 1'b0;
      count_lit(5'h04, n);
      check(n inside {[1:19]}, 1'b1);
      count_lit(5'h08, n);
      check(n inside {[1:19]}, 1'b1);
      presence_i = 1'b0;
      serial_tx_i = 1'b0;
      wait_ms(200);
      decode_ok_i = 1'b1;
      @(negedge clk_i);
      decode_ok_i = 1'b0;
      count_lit(5'h02, n);
      check(n inside {[1:19]}, 1'b1);
      want = 2'b01;
      wait_ms(150);
      check(lamp_o[4], 1'b1);
      wait_ms(160);
      check(lamp_o[3], 1'b1);
      hold_func(2);
      wait_ms(10);
      check(test_mode_o, 1'b1);
      check($countones(lamp_o), 3);
      read_rate_i = 7'h00;
      wait_ms(5);
      check(lamp_o[3:0], 4'h0);
      wait_ms(60);
      check(test_mode_o, 1'b0);
      hold_func(312);
      wait_ms(10);
      hold_func(10);
      wait_ms(10);
      check(test_mode_o, 1'b0);
      hold_func(332);
      wait_ms(5);
      check(learn_mode_o, 1'b1);
      count_lit(5'h04, n);
      check(n inside {[1:19]}, 1'b1);
      wait_ms(120);
      check({learn_mode_o, n_discard[3:0]}, 5'h01);
      hold_func(332);
      wait_ms(20);
      learn_saved_i = 1'b1;
      @(negedge clk_i);
      learn_saved_i = 1'b0;
      wait_ms(100);
      count_lit(5'h04, n);
      check(n, 20);
      wait_ms(800);
      check(n_discard, 1);
      hold_func(352);
      wait_ms(10);
      check(setup_port_only_o, 1'b0);
      chain_scanner_master_i = 1'b1;
      last_slave_i = 1'b1;
      hold_func(352);
      wait_ms(10);
      check(setup_port_only_o, 1'b1);
      hold_func(10);
      wait_ms(10);
      check(setup_port_only_o, 1'b0);
      hold_func(372);
      wait_ms(10);
      check(discovery_mode_o, 1'b0);
      role_master_i = 1'b1;
      hold_func(372);
      wait_ms(10);
      check(discovery_mode_o, 1'b1);
      hold_func(10);
      wait_ms(10);
      check(discovery_mode_o, 1'b0);
      want = 2'b10;
      wait_ms(1100);
      check(lamp_o, 5'h1F);
      want = 2'b00;
      wait_ms(250);
      check(lamp_o, 5'h00);
      wait_ms(350);
      check({use_box_params_o, lamp_o[0]}, 2'h3);
      do_reset(2'b01);
      wait_ms(50);
      want = 2'b00;
      wait_ms(50);
      check({recovery_mode_o, factory_restore_o}, 2'h2);
      do_reset(2'b11);
      wait_ms(50);
      want = 2'b00;
      wait_ms(50);
      check({recovery_mode_o, factory_restore_o}, 2'h1);
      defaults_done_i = 1'b1;
      @(negedge clk_i);
      defaults_done_i = 1'b0;
      n_all = 0;
      wait_ms(800);
      check(n_all, 3);
      final_report();
   end
endmodule
